// >>> design/sync_serial_pkg.sv
// Purpose: Shared constants and types for the synchronous serial port shift engine.
// Assumes: System clock of 40 MHz; all counts are in system clock cycles.
// Notes:   Mode codes, rate divisors and status layout live here only.
package sync_serial_pkg;

    // Bits in one transfer
    localparam int BITS_PER_BYTE = 8;

    // Mode select codes
    localparam logic [3:0] MODE_MASTER_DIV4 = 4'h0;
    localparam logic [3:0] MODE_MASTER_DIV16 = 4'h1;
    localparam logic [3:0] MODE_MASTER_DIV64 = 4'h2;
    localparam logic [3:0] MODE_MASTER_TIMER = 4'h3;
    localparam logic [3:0] MODE_SLAVE_SS = 4'h4;
    localparam logic [3:0] MODE_SLAVE_NOSS = 4'h5;
    localparam logic [3:0] MODE_MASTER_RELOAD = 4'hA;

    // Oscillator divisors per bit, and the matching half periods
    localparam int DIV_FOSC4 = 4;
    localparam int DIV_FOSC16 = 16;
    localparam int DIV_FOSC64 = 64;
    localparam int HALF_DIV4 = DIV_FOSC4 / 2;
    localparam int HALF_DIV16 = DIV_FOSC16 / 2;
    localparam int HALF_DIV64 = DIV_FOSC64 / 2;

    // Half-period tick positions inside one master byte
    localparam logic [4:0] TICK_FIRST = 5'h01;
    localparam logic [4:0] TICK_FIRST_LATE = 5'h03;
    localparam logic [4:0] TICK_LAST = 5'h10;
    localparam logic [4:0] TICK_LAST_LATE = 5'h11;

    // Reset values and the last bit count
    localparam logic [7:0] BUFFER_RESET = 8'h00;
    localparam logic [7:0] SHIFT_RESET = 8'h00;
    localparam logic [2:0] COUNT_RESET = 3'h0;
    localparam logic [2:0] COUNT_LAST = 3'h7;

    // Master bit-rate sources
    typedef enum logic [2:0] {RATE_DIV4, RATE_DIV16, RATE_DIV64, RATE_TIMER, RATE_RELOAD} rate_t;

    // Configuration written by software
    typedef struct packed {
        logic port_enable;
        logic [3:0] mode_select;
        logic clock_polarity;
        logic clock_edge;
        logic sample_phase;
        logic overwrite_enable;
        logic sdo_disable;
        logic [7:0] rate_reload;
    } cfg_t;

    // Status seen by software
    typedef struct packed {
        logic buffer_full;
        logic port_irq_flag;
        logic write_collision;
        logic busy;
    } status_t;

endpackage : sync_serial_pkg

// >>> design/sync2.sv
// Purpose: Two flip-flop synchroniser for levels entering the system clock domain.
// Assumes: Each bit is an independent level, or a toggle held long enough to be seen.
// Notes:   The first stage is read by the second stage only.
`timescale 1ns/1ps
module sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_ni,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] q;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // Shift the input through both stages
    always_comb
    begin
        state_next = state_reg;
        state_next.meta = d_i;
        state_next.q = state_reg.meta;
    end

    // State registers
    always_ff @(posedge clk_i or negedge rst_ni)
    begin
        if (!rst_ni)
        begin
            state_reg <= {RESET_VAL, RESET_VAL};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign q_o = state_reg.q;

endmodule : sync2

// >>> design/rate_gen.sv
// Purpose: Half-period tick generator for the master serial clock.
// Assumes: Timer tick is a one-cycle pulse from logic on the same clock.
// Notes:   One tick per SCK half period; the timer source toggles SCK per pulse.
`timescale 1ns/1ps
module rate_gen #(
    parameter int CNT_W = 10
) (
    input wire logic clk_i,
    input wire logic rst_ni,
    input wire logic run_i,
    input sync_serial_pkg::rate_t sel_i,
    input wire logic [7:0] reload_i,
    input wire logic timer_tick_i,
    output logic tick_o
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } state_t;

    state_t state_reg;
    state_t state_next;
    logic [CNT_W-1:0] limit;

    // Terminal count for each source
    always_comb
    begin
        case (sel_i)
            sync_serial_pkg::RATE_DIV4: limit = CNT_W'(sync_serial_pkg::HALF_DIV4 - 1);
            sync_serial_pkg::RATE_DIV16: limit = CNT_W'(sync_serial_pkg::HALF_DIV16 - 1);
            sync_serial_pkg::RATE_DIV64: limit = CNT_W'(sync_serial_pkg::HALF_DIV64 - 1);
            sync_serial_pkg::RATE_RELOAD: limit = CNT_W'({reload_i, 1'b1}); // 2*(reload+1)-1
            default: limit = '0;
        endcase
    end

    // Count cycles and emit one tick per half period
    always_comb
    begin
        state_next = state_reg;
        tick_o = 1'b0;
        if (!run_i)
        begin
            state_next.cnt = '0;
        end
        else if (sel_i == sync_serial_pkg::RATE_TIMER)
        begin
            tick_o = timer_tick_i; // Timer output halved: one SCK edge per pulse
        end
        else if (state_reg.cnt == limit)
        begin
            state_next.cnt = '0;
            tick_o = 1'b1;
        end
        else
        begin
            state_next.cnt = state_reg.cnt + CNT_W'(1);
        end
    end

    // State registers
    always_ff @(posedge clk_i or negedge rst_ni)
    begin
        if (!rst_ni)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

endmodule : rate_gen

// >>> design/sync_serial_port.sv
// Purpose: SPI shift engine of a synchronous serial port, master or slave.
// Assumes: clk_i at 40 MHz; slave shifting clocked by the external SCK pin.
// Notes:   Slave shifting runs on SCK alone; received bytes reach the buffer and flags only through clk_i.
`timescale 1ns/1ps
module sync_serial_port #(
    parameter int RATE_CNT_W = 10
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input sync_serial_pkg::cfg_t cfg_i,
    input wire logic buf_wr_i,
    input wire logic [7:0] buf_wdata_i,
    input wire logic buf_rd_i,
    output logic [7:0] buf_rdata_o,
    input wire logic write_collision_clr_i,
    input wire logic irq_clr_i,
    input wire logic timer_tick_i,
    output sync_serial_pkg::status_t status_o,
    input wire logic sck_link_i,
    output logic sck_o,
    output logic sck_oe_o,
    input wire logic sdi_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    input wire logic ss_n_i
);

    typedef enum {M_IDLE, M_RUN} mstate_t;

    // System-domain state
    typedef struct packed {
        mstate_t mstate;
        logic [7:0] shift_reg;
        logic [7:0] rx_shift;
        logic [4:0] tick_cnt;
        logic sck_active;
        logic [7:0] data_buffer;
        logic buffer_full;
        logic port_irq_flag;
        logic write_collision;
        logic done_seen;
        logic samp_pend;
        logic done_pend;
    } sys_t;

    // Link-domain shift state, cleared by any port reset
    typedef struct packed {
        logic [7:0] shift_reg;
        logic [2:0] bit_cnt;
        logic busy;
    } link_t;

    // Link-domain completion record, kept across disable and select resets
    typedef struct packed {
        logic [7:0] rx_byte;
        logic done_tgl;
    } event_t;

    sys_t sys_reg;
    sys_t sys_next;
    link_t link_reg;
    link_t link_next;
    event_t evt_reg;
    event_t evt_next;
    logic launch_reg;

    logic rst_n;
    logic is_master;
    logic is_slave;
    logic ss_ctl;
    logic link_rst_n;
    logic link_clk;
    logic done_s;
    logic busy_s;
    logic sdi_s;
    logic tick;
    logic mrun;
    logic busy;
    sync_serial_pkg::rate_t rate_sel;

    // Reset release through two flip-flops
    sync2 #(.WIDTH(1), .RESET_VAL(1'b0)) u_rst_sync (
        .clk_i(clk_i),
        .rst_ni(rstn_i),
        .d_i(1'b1),
        .q_o(rst_n)
    );

    // Mode decode; nothing runs without the enable
    always_comb
    begin
        is_master = 1'b0;
        is_slave = 1'b0;
        rate_sel = sync_serial_pkg::RATE_DIV4;
        case (cfg_i.mode_select)
            sync_serial_pkg::MODE_MASTER_DIV4:
            begin
                is_master = 1'b1;
                rate_sel = sync_serial_pkg::RATE_DIV4;
            end
            sync_serial_pkg::MODE_MASTER_DIV16:
            begin
                is_master = 1'b1;
                rate_sel = sync_serial_pkg::RATE_DIV16;
            end
            sync_serial_pkg::MODE_MASTER_DIV64:
            begin
                is_master = 1'b1;
                rate_sel = sync_serial_pkg::RATE_DIV64;
            end
            sync_serial_pkg::MODE_MASTER_TIMER:
            begin
                is_master = 1'b1;
                rate_sel = sync_serial_pkg::RATE_TIMER;
            end
            sync_serial_pkg::MODE_MASTER_RELOAD:
            begin
                is_master = 1'b1;
                rate_sel = sync_serial_pkg::RATE_RELOAD;
            end
            sync_serial_pkg::MODE_SLAVE_SS,
            sync_serial_pkg::MODE_SLAVE_NOSS:
            begin
                is_slave = 1'b1;
            end
            default:
            begin
                is_master = 1'b0;
            end
        endcase
        is_master = is_master & cfg_i.port_enable;
        is_slave = is_slave & cfg_i.port_enable;
    end

    assign ss_ctl = is_slave && (cfg_i.mode_select == sync_serial_pkg::MODE_SLAVE_SS);

    // Slave engine reset: system reset, disable, or select high in MODE_SLAVE_SS
    assign link_rst_n = rst_n & is_slave & ~(ss_ctl & ss_n_i);

    // Sample edge rises on link_clk for every polarity and edge setting
    assign link_clk = sck_link_i ^ cfg_i.clock_polarity ^ ~cfg_i.clock_edge;

    // Slave shift: the first edge of a byte takes the buffer contents
    always_comb
    begin
        link_next = link_reg;
        if (link_reg.bit_cnt == sync_serial_pkg::COUNT_RESET)
        begin
            link_next.shift_reg = {sys_reg.data_buffer[6:0], sdi_i};
        end
        else
        begin
            link_next.shift_reg = {link_reg.shift_reg[6:0], sdi_i};
        end
        link_next.bit_cnt = link_reg.bit_cnt + 3'h1;
        link_next.busy = (link_next.bit_cnt != sync_serial_pkg::COUNT_RESET);
    end

    // Byte completion record, toggled on the last latched bit
    always_comb
    begin
        evt_next = evt_reg;
        if (link_reg.bit_cnt == sync_serial_pkg::COUNT_LAST)
        begin
            evt_next.rx_byte = link_next.shift_reg;
            evt_next.done_tgl = ~evt_reg.done_tgl;
        end
    end

    // Slave shift registers on the sample edge
    always_ff @(posedge link_clk or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            link_reg <= '{shift_reg: sync_serial_pkg::SHIFT_RESET, bit_cnt: sync_serial_pkg::COUNT_RESET,
                          busy: 1'b0};
        end
        else
        begin
            link_reg <= link_next;
        end
    end

    // Completion record survives select resets so no false event appears
    always_ff @(posedge link_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            evt_reg <= '{rx_byte: sync_serial_pkg::SHIFT_RESET, done_tgl: 1'b0};
        end
        else
        begin
            evt_reg <= evt_next;
        end
    end

    // Launch the next bit on the opposite edge
    always_ff @(negedge link_clk or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            launch_reg <= 1'b0;
        end
        else
        begin
            launch_reg <= link_reg.shift_reg[7];
        end
    end

    // Crossings into the system domain
    sync2 #(.WIDTH(3), .RESET_VAL(3'h0)) u_in_sync (
        .clk_i(clk_i),
        .rst_ni(rst_n),
        .d_i({evt_reg.done_tgl, link_reg.busy, sdi_i}),
        .q_o({done_s, busy_s, sdi_s})
    );

    assign mrun = is_master && (sys_reg.mstate == M_RUN);

    // Master half-period ticks
    rate_gen #(.CNT_W(RATE_CNT_W)) u_rate (
        .clk_i(clk_i),
        .rst_ni(rst_n),
        .run_i(mrun),
        .sel_i(rate_sel),
        .reload_i(cfg_i.rate_reload),
        .timer_tick_i(timer_tick_i),
        .tick_o(tick)
    );

    assign busy = mrun | (is_slave & busy_s);

    // Master sequencing, buffer and flags
    always_comb
    begin
        logic [4:0] k1;
        logic late;
        logic [4:0] last_tick;
        logic [4:0] first_sample;
        logic [7:0] rx_now;
        logic m_done;
        logic s_done;
        logic byte_done;
        logic [7:0] byte_in;
        sys_next = sys_reg;
        k1 = sys_reg.tick_cnt + 5'h01;
        late = ~cfg_i.clock_edge & cfg_i.sample_phase;
        last_tick = late ? sync_serial_pkg::TICK_LAST_LATE : sync_serial_pkg::TICK_LAST;
        first_sample = late ? sync_serial_pkg::TICK_FIRST_LATE : sync_serial_pkg::TICK_FIRST;
        rx_now = sys_reg.rx_shift;
        m_done = 1'b0;
        sys_next.samp_pend = 1'b0;
        sys_next.done_seen = done_s;
        // Sample lands one cycle after its tick; the input synchroniser lags a fast half period
        if (sys_reg.samp_pend)
        begin
            rx_now = {sys_reg.rx_shift[6:0], sdi_s};
            sys_next.rx_shift = rx_now;
        end
        s_done = is_slave & (done_s != sys_reg.done_seen);
        if (!is_master)
        begin
            sys_next.mstate = M_IDLE;
            sys_next.tick_cnt = 5'h00;
            sys_next.sck_active = 1'b0;
            sys_next.done_pend = 1'b0;
        end
        else
        begin
            case (sys_reg.mstate)
                M_IDLE:
                begin
                    sys_next.tick_cnt = 5'h00;
                end
                M_RUN:
                begin
                    // Byte ends the cycle after the last tick, once the last sample is in
                    if (sys_reg.done_pend)
                    begin
                        m_done = 1'b1;
                        sys_next.done_pend = 1'b0;
                        sys_next.mstate = M_IDLE;
                        sys_next.tick_cnt = 5'h00;
                    end
                    else if (tick)
                    begin
                        sys_next.tick_cnt = k1;
                        if (k1 <= sync_serial_pkg::TICK_LAST)
                        begin
                            sys_next.sck_active = k1[0];
                        end
                        // Sample at middle or end of the output time
                        if ((k1[0] == (cfg_i.clock_edge ^ cfg_i.sample_phase)) && (k1 >= first_sample))
                        begin
                            sys_next.samp_pend = 1'b1;
                        end
                        // Launch the next bit on the programmed edge
                        if (cfg_i.clock_edge ? (!k1[0] && k1 < sync_serial_pkg::TICK_LAST)
                                             : (k1[0] && k1 >= sync_serial_pkg::TICK_FIRST_LATE
                                                && k1 < sync_serial_pkg::TICK_LAST))
                        begin
                            sys_next.shift_reg = {sys_reg.shift_reg[6:0], 1'b0};
                        end
                        if (k1 == last_tick)
                        begin
                            sys_next.done_pend = 1'b1;
                        end
                    end
                end
                default:
                begin
                    sys_next.mstate = M_IDLE;
                end
            endcase
        end

        // Software write: accepted only when idle and collision flag clear
        if (write_collision_clr_i)
        begin
            sys_next.write_collision = 1'b0;
        end
        if (buf_wr_i && cfg_i.port_enable)
        begin
            if (busy)
            begin
                sys_next.write_collision = 1'b1;
            end
            else if (!sys_reg.write_collision)
            begin
                sys_next.data_buffer = buf_wdata_i;
                if (is_master)
                begin
                    sys_next.shift_reg = buf_wdata_i;
                    sys_next.rx_shift = sync_serial_pkg::SHIFT_RESET;
                    sys_next.mstate = M_RUN;
                    sys_next.tick_cnt = 5'h00;
                end
            end
        end

        // Received byte: load buffer if not full, read this cycle or overwrite enabled; set flags; set wins over clear
        byte_done = m_done | s_done;
        byte_in = m_done ? rx_now : evt_reg.rx_byte;
        if (buf_rd_i)
        begin
            sys_next.buffer_full = 1'b0;
        end
        if (irq_clr_i)
        begin
            sys_next.port_irq_flag = 1'b0;
        end
        if (byte_done)
        begin
            if (!sys_reg.buffer_full || buf_rd_i || cfg_i.overwrite_enable)
            begin
                sys_next.data_buffer = byte_in;
            end
            sys_next.buffer_full = 1'b1;
            sys_next.port_irq_flag = 1'b1;
        end
    end

    // System-domain registers
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sys_reg <= '{mstate: M_IDLE, shift_reg: sync_serial_pkg::SHIFT_RESET,
                         rx_shift: sync_serial_pkg::SHIFT_RESET, tick_cnt: 5'h00, sck_active: 1'b0,
                         data_buffer: sync_serial_pkg::BUFFER_RESET, buffer_full: 1'b0,
                         port_irq_flag: 1'b0, write_collision: 1'b0, done_seen: 1'b0,
                         samp_pend: 1'b0, done_pend: 1'b0};
        end
        else
        begin
            sys_reg <= sys_next;
        end
    end

    // Pin drive
    assign sck_o = cfg_i.clock_polarity ^ sys_reg.sck_active;
    assign sck_oe_o = is_master;
    assign sdo_o = is_master ? sys_reg.shift_reg[7] :
                   ((link_reg.bit_cnt == sync_serial_pkg::COUNT_RESET) ? sys_reg.data_buffer[7] : launch_reg);
    assign sdo_oe_o = is_master ? ~cfg_i.sdo_disable : (is_slave & ~(ss_ctl & ss_n_i));

    // Software view
    assign buf_rdata_o = sys_reg.data_buffer;
    assign status_o = '{buffer_full: sys_reg.buffer_full, port_irq_flag: sys_reg.port_irq_flag,
                        write_collision: sys_reg.write_collision, busy: busy};

endmodule : sync_serial_port

// >>> testbench/sync_serial_port_chk.sv
// Purpose: Port-level assertions for the serial port shift engine.
// Assumes: One clk_i domain; configuration steady while a byte runs.
// Notes: Bound into every sync_serial_port instance.
`timescale 1ns/1ps
module sync_serial_port_chk (
    input wire logic clk_i,
    input wire logic rstn_i,
    input sync_serial_pkg::cfg_t cfg_i,
    input wire logic buf_wr_i,
    input wire logic buf_rd_i,
    input sync_serial_pkg::status_t status_o,
    input wire logic sck_o,
    input wire logic sck_oe_o,
    input wire logic sdo_oe_o,
    input wire logic ss_n_i
);
    logic m0;
    logic m4;
    // Decoded mode conditions
    assign m0 = cfg_i.port_enable && cfg_i.mode_select == sync_serial_pkg::MODE_MASTER_DIV4;
    assign m4 = cfg_i.port_enable && cfg_i.mode_select == sync_serial_pkg::MODE_SLAVE_SS;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    a_off_no_sck: assert property (!cfg_i.port_enable |-> !sck_oe_o)
        else $error("SCK driven while port off");
    a_sck_idle_level: assert property (sck_oe_o && !status_o.busy |-> sck_o == cfg_i.clock_polarity)
        else $error("SCK not at idle level");
    a_ss_release: assert property (m4 && ss_n_i |-> !sdo_oe_o)
        else $error("SDO driven while deselected");
    a_ss_drive: assert property (m4 && !ss_n_i |-> sdo_oe_o)
        else $error("SDO not driven while selected");
    a_write_collision_set: assert property (cfg_i.port_enable && buf_wr_i && status_o.busy |=> status_o.write_collision)
        else $error("Collision flag not set");
    a_write_collision_blocks: assert property (m0 && buf_wr_i && !status_o.busy && status_o.write_collision |=> !status_o.busy)
        else $error("Write accepted with collision flag set");
    a_master_start: assert property (m0 && buf_wr_i && !status_o.busy && !status_o.write_collision |=> status_o.busy)
        else $error("Master transfer did not start");
    a_byte_length: assert property (m0 && $rose(status_o.busy) |-> status_o.busy [*8] ##[20:28] !status_o.busy)
        else $error("Master byte length wrong");
    a_done_flags: assert property (m0 && $fell(status_o.busy) |-> status_o.buffer_full && status_o.port_irq_flag)
        else $error("Flags not set at byte end");
    a_read_clears: assert property (buf_rd_i && !status_o.busy |=> !status_o.buffer_full)
        else $error("Read did not clear full flag");
endmodule : sync_serial_port_chk

bind sync_serial_port sync_serial_port_chk i_sync_serial_port_chk (.clk_i(clk_i), .rstn_i(rstn_i), .cfg_i(cfg_i),
    .buf_wr_i(buf_wr_i), .buf_rd_i(buf_rd_i), .status_o(status_o), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
    .sdo_oe_o(sdo_oe_o), .ss_n_i(ss_n_i));

// >>> testbench/spi_far_model.sv
// Purpose: Far SPI party: slave to the port's SCK, or master of the link.
// Assumes: Polarity 0; clock-edge 1 framing, or late framing as slave when late_i is high.
// Notes: Link clock stands still between frames; 6 ns period inside.
`timescale 1ns/1ps
module spi_far_model (
    input wire logic sck_i,
    input wire logic sdo_i,
    input wire logic master_i,
    input wire logic late_i,
    output logic sck_o,
    output logic ss_n_o,
    output logic sdi_o
);
    logic [7:0] sh = 8'h00;
    logic cap = 1'b0;
    logic hold = 1'b0;
    // Top bit on the data line; late framing shows it from the last rising edge
    assign sdi_o = (late_i && !master_i) ? hold : sh[7];
    // Slave role: capture rising and shift falling, or capture and shift falling when late
    always @(posedge sck_i)
    begin
        if (!master_i)
        begin
            cap <= sdo_i;
            hold <= sh[7];
        end
    end
    always @(negedge sck_i) if (!master_i) sh <= late_i ? {sh[6:0], sdo_i} : {sh[6:0], cap};
    // Idle clock level before the port is enabled
    initial sck_o = 1'b0;
    initial ss_n_o = 1'b1;
    // Master role: select, n pulses, settle, deselect
    task automatic xfer(input logic [7:0] d, input int n);
        sh = d;
        ss_n_o = 1'b0;
        #20;
        repeat (n)
        begin
            #3 sck_o = 1'b1;
            cap = sdo_i;
            #3 sck_o = 1'b0;
            sh = {sh[6:0], cap};
        end
        #150 ss_n_o = 1'b1;
        #50;
    endtask : xfer
endmodule : spi_far_model

// >>> testbench/testbench.sv
// Purpose: Self-checking bench for the serial port in master and slave roles.
// Assumes: Inputs driven at falling clk; far party modelled separately.
// Notes: Each scenario is a sequence of port tasks with expected values.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module testbench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    sync_serial_pkg::cfg_t cfg = '0;
    sync_serial_pkg::status_t st;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic wclr = 1'b0;
    logic iclr = 1'b0;
    logic tick = 1'b0;
    logic msr = 1'b0;
    logic [7:0] wd = 8'h00;
    logic [7:0] rdata;
    logic sck, sck_oe, sdo, sdo_oe, link, sdi, ssn, sdo_w;
    logic sdo_last = 1'b0;
    logic [3:0] modes [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hA};
    int n_errors = 0;
    int n_checks = 0;
    int tc = 0;
    // Clock and a free-running timer pulse every third cycle
    always #12.5 clk = ~clk;
    always @(negedge clk)
    begin
        tc = (tc + 1) % 3;
        tick <= (tc == 0);
    end
    // Released data line shows the inverse of its last level
    always @(sdo or sdo_oe) if (sdo_oe) sdo_last = sdo;
    assign sdo_w = sdo_oe ? sdo : ~sdo_last;
    sync_serial_port i_sync_serial_port (.clk_i(clk), .rstn_i(rstn), .cfg_i(cfg), .buf_wr_i(wr), .buf_wdata_i(wd),
        .buf_rd_i(rd), .buf_rdata_o(rdata), .write_collision_clr_i(wclr), .irq_clr_i(iclr), .timer_tick_i(tick),
        .status_o(st), .sck_link_i(link), .sck_o(sck), .sck_oe_o(sck_oe), .sdi_i(sdi), .sdo_o(sdo),
        .sdo_oe_o(sdo_oe), .ss_n_i(ssn));
    // Master SCK feeds the far party directly
    spi_far_model i_spi_far_model (.sck_i(sck), .sdo_i(sdo_w), .master_i(msr), .late_i(!cfg.clock_edge),
        .sck_o(link), .ss_n_o(ssn), .sdi_o(sdi));
    // Disable, rewrite, re-enable; reload mode runs edge clear with end sampling
    task automatic setup(input logic [3:0] m, input logic p, input logic dis, input logic ow);
        @(negedge clk) cfg.port_enable = 1'b0;
        @(negedge clk) cfg = '{1'b1, m, p, m != 4'hA, m == 4'hA, ow, dis, 8'h01};
        @(negedge clk);
    endtask : setup
    task automatic put(input logic [7:0] d);
        @(negedge clk)
        begin
            wr = 1'b1;
            wd = d;
        end
        @(negedge clk) wr = 1'b0;
    endtask : put
    task automatic strobe(ref logic s);
        @(negedge clk) s = 1'b1;
        @(negedge clk) s = 1'b0;
    endtask : strobe
    task automatic wait_idle;
        int k;
        k = 0;
        while (st.busy !== 1'b0 && k < 1000)
        begin
            @(negedge clk);
            k++;
        end
        if (k == 1000) begin n_errors++; end_of_test; end
    endtask : wait_idle
    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    initial
    begin
        repeat (12) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        `CHK(st, 4'h0)
        `CHK(rdata, 8'h00)
        `CHK(sck_oe, 1'b0)
        setup(4'h0, 1'b1, 1'b0, 1'b0);
        `CHK({sck_oe, sck}, 2'b11)
        // Master byte in every rate source; sdo disabled in one
        for (int i = 0; i < 5; i++)
        begin
            setup(modes[i], 1'b0, i == 1, 1'b0);
            i_spi_far_model.sh = 8'h96 ^ 8'(i);
            put(8'h3C + 8'(i));
            `CHK(rdata, 8'h3C + 8'(i))
            `CHK(sdo_oe, i != 1)
            if (i == 0) put(8'hFF);
            wait_idle;
            `CHK(st.write_collision, i == 0)
            `CHK(rdata, 8'h96 ^ 8'(i))
            `CHK({st.buffer_full, st.port_irq_flag}, 2'b11)
            if (i != 1) `CHK(i_spi_far_model.sh, 8'h3C + 8'(i))
            put(8'h11);
            @(negedge clk);
            `CHK(st.busy, i == 0 ? 1'b0 : 1'b1)
            wait_idle;
            strobe(wclr);
            strobe(rd);
            `CHK({st.buffer_full, st.port_irq_flag, st.write_collision}, 3'b010)
            strobe(iclr);
            `CHK(st.port_irq_flag, 1'b0)
        end
        // Slave with select: abort mid-byte, then full bytes
        msr = 1'b1;
        setup(4'h4, 1'b0, 1'b0, 1'b0);
        put(8'hC3);
        `CHK(sdo_oe, 1'b0)
        i_spi_far_model.xfer(8'hFF, 3);
        `CHK({sdo_oe, st.port_irq_flag}, 2'b00)
        i_spi_far_model.xfer(8'h5A, 8);
        `CHK(i_spi_far_model.sh, 8'hC3)
        `CHK(rdata, 8'h5A)
        `CHK({st.buffer_full, st.port_irq_flag}, 2'b11)
        i_spi_far_model.xfer(8'h81, 8);
        `CHK(rdata, 8'h5A)
        `CHK(i_spi_far_model.sh, 8'h5A)
        @(negedge clk) cfg.overwrite_enable = 1'b1;
        i_spi_far_model.xfer(8'h24, 8);
        `CHK(rdata, 8'h24)
        setup(4'h5, 1'b0, 1'b0, 1'b0);
        `CHK({sdo_oe, sck_oe}, 2'b10)
        end_of_test;
    end
endmodule : testbench
